// ==== design/phr_consts.svh ====
// Offsets, field positions, reset values and timing counts of the header field registers.
`ifndef PHR_CONSTS_SVH
`define PHR_CONSTS_SVH

`define PHR_ADDR_W          8
`define PHR_DATA_W          8

`define PHR_OFS_TX_CFG      8'h50
`define PHR_OFS_TX_SVC      8'h54
`define PHR_OFS_TX_LEN_HI   8'h58
`define PHR_OFS_TX_LEN_LO   8'h5c
`define PHR_OFS_RX_STAT     8'h60
`define PHR_OFS_RX_SVC      8'h64
`define PHR_OFS_RX_LEN_HI   8'h68
`define PHR_OFS_RX_LEN_LO   8'h6c

`define PHR_CFG_NOHDR_BIT   2
`define PHR_CFG_RATE_LSB    0
`define PHR_STAT_RATE_LSB   6
`define PHR_STAT_ACQ_BIT    5
`define PHR_STAT_SFD_BIT    4
`define PHR_STAT_SIG_BIT    3
`define PHR_STAT_CRC_BIT    2
`define PHR_STAT_ANT_BIT    1

`define PHR_RST_BYTE        8'h00
`define PHR_RST_RATE        2'h0

`define PHR_CLK_PERIOD_PS   5000
`define PHR_RATE_SETUP_NS   2000
`define PHR_RATE_SETUP_CYC  ((`PHR_RATE_SETUP_NS * 1000 + `PHR_CLK_PERIOD_PS - 1) / `PHR_CLK_PERIOD_PS)
`define PHR_SETUP_CNT_W     9

`endif

// ==== design/phr_pkg.sv ====
// Types shared by the header field register bank.
`include "phr_consts.svh"

package phr_pkg;

    typedef logic [1:0] phr_rate_type;

    typedef logic [3:0][7:0] phr_codes_type;

    typedef struct packed {
        logic         headerless;
        phr_rate_type rate;
        logic [7:0]   signal;
        logic [7:0]   service;
        logic [15:0]  length;
    } phr_tx_hdr_type;

    typedef struct packed {
        logic        acquired;
        logic        sfd_found;
        logic        sig_valid;
        logic [7:0]  sig_byte;
        logic        svc_valid;
        logic [7:0]  svc_byte;
        logic        len_valid;
        logic [15:0] len;
        logic        crc_done;
        logic        crc_ok;
        logic        antenna_a;
    } phr_rx_evt_type;

    typedef struct packed {
        logic [7:0]                  cfg;
        logic [7:0]                  svc;
        logic [7:0]                  len_hi;
        logic [7:0]                  len_lo;
        phr_rate_type                rx_rate;
        logic                        acq;
        logic                        sfd;
        logic                        sig_ok;
        logic                        crc_ok;
        logic                        ant_a;
        logic [7:0]                  rx_svc;
        logic [15:0]                 rx_len;
        logic [7:0]                  rdata;
        logic [`PHR_SETUP_CNT_W-1:0] setup_cnt;
    } phr_state_type;

endpackage

// ==== design/phr_sig_match.sv ====
// Compares a received signal byte against the four programmed signal field codes.
`timescale 1ns/1ps
`default_nettype none
`include "phr_consts.svh"

module phr_sig_match
    import phr_pkg::*;
(
    // Codes and candidate.
    input  wire phr_codes_type codes,
    input  wire logic [7:0]    sig_byte,
    // Result.
    output logic               hit,
    output phr_rate_type       idx
);

    always_comb begin
        hit = 1'b0;
        idx = `PHR_RST_RATE;
        for (int i = 3; i >= 0; i--) begin
            if (codes[i] == sig_byte) begin
                hit = 1'b1;
                idx = phr_rate_type'(i);
            end
        end
    end

endmodule

`default_nettype wire

// ==== design/phr_tx_hdr.sv ====
// Builds the registered transmit header fields from the configuration bytes.
`timescale 1ns/1ps
`default_nettype none
`include "phr_consts.svh"

module phr_tx_hdr
    import phr_pkg::*;
(
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          srst,
    // Configuration.
    input  wire logic [7:0]    cfg,
    input  wire logic [7:0]    svc,
    input  wire logic [7:0]    len_hi,
    input  wire logic [7:0]    len_lo,
    input  wire phr_codes_type codes,
    // Header fields.
    output phr_tx_hdr_type     hdr
);

    phr_tx_hdr_type hdr_d;
    phr_tx_hdr_type hdr_q;

    always_comb begin
        hdr_d.headerless = cfg[`PHR_CFG_NOHDR_BIT];
        hdr_d.rate       = cfg[`PHR_CFG_RATE_LSB +: 2];
        hdr_d.signal     = codes[cfg[`PHR_CFG_RATE_LSB +: 2]];
        hdr_d.service    = svc;
        hdr_d.length     = {len_hi, len_lo};
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hdr_q <= '0;
        end else begin
            hdr_q <= hdr_d;
        end
    end

    assign hdr = hdr_q;

endmodule

`default_nettype wire

// ==== design/phr_regs.sv ====
// Header field register bank: transmit header configuration and receive header status.
//
// Notes on behaviour
// - Config bit 2 set sends 2 Mbps QPSK without header; rate must be 00.
// - Rate field 00/01/10/11 selects 1, 2, 5.5 or 11 Mbps modulation.
// - Rate field picks which of four signal codes goes into the header.
// - Transmit service byte is sent as the header service field.
// - Transmit length high byte gives length bits 15:8.
// - Transmit length low byte gives length bits 7:0.
// - Status bits 7:6 give detected rate, forced to 00 while receive disabled.
// - Status bit 5 shows carrier acquired, cleared while receive disabled.
// - Status bit 4 shows delimiter found, cleared while receive disabled.
// - Status bit 3 set only if signal byte matches a code, else 0.
// - Status bit 2 shows header check good, cleared while receive disabled.
// - Status bit 1 holds antenna of last good header check; bit 0 reads 0.
// - Receive service register holds the received service byte.
// - Receive length high register holds received length bits 15:8.
// - Receive length low register holds received length bits 7:0.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "phr_consts.svh"

module phr_regs
    import phr_pkg::*;
(
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   srst,
    // Register port.
    input  wire logic [`PHR_ADDR_W-1:0] addr,
    input  wire logic [`PHR_DATA_W-1:0] wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic [`PHR_DATA_W-1:0]      rdata,
    // Signal field codes held elsewhere.
    input  wire phr_codes_type          codes,
    // Receive side.
    input  wire logic                   receive_enable_in,
    input  wire phr_rx_evt_type         rx_evt,
    // Transmit side.
    output phr_tx_hdr_type              tx_hdr,
    output logic                        tx_rate_ready
);

    phr_state_type s_q;
    phr_state_type s_d;
    logic          sig_hit;
    phr_rate_type  sig_idx;

    function automatic logic hit_addr(input logic [`PHR_ADDR_W-1:0] a,
                                      input logic [`PHR_ADDR_W-1:0] ofs);
        hit_addr = (a == ofs);
    endfunction

    function automatic logic [7:0] status_byte(input phr_state_type s);
        status_byte = '0;
        status_byte[`PHR_STAT_RATE_LSB +: 2] = s.rx_rate;
        status_byte[`PHR_STAT_ACQ_BIT]       = s.acq;
        status_byte[`PHR_STAT_SFD_BIT]       = s.sfd;
        status_byte[`PHR_STAT_SIG_BIT]       = s.sig_ok;
        status_byte[`PHR_STAT_CRC_BIT]       = s.crc_ok;
        status_byte[`PHR_STAT_ANT_BIT]       = s.ant_a;
    endfunction

    phr_sig_match u_match (
        .codes    (codes),
        .sig_byte (rx_evt.sig_byte),
        .hit      (sig_hit),
        .idx      (sig_idx)
    );

    phr_tx_hdr u_tx (
        .clk    (clk),
        .srst   (srst),
        .cfg    (s_q.cfg),
        .svc    (s_q.svc),
        .len_hi (s_q.len_hi),
        .len_lo (s_q.len_lo),
        .codes  (codes),
        .hdr    (tx_hdr)
    );

    always_comb begin
        s_d = s_q;

        // Writable configuration; the status offsets take no write.
        if (wr) begin
            if (hit_addr(addr, `PHR_OFS_TX_CFG)) begin
                s_d.cfg       = wdata;
                s_d.setup_cnt = `PHR_SETUP_CNT_W'(`PHR_RATE_SETUP_CYC);
            end
            if (hit_addr(addr, `PHR_OFS_TX_SVC)) begin
                s_d.svc = wdata;
            end
            if (hit_addr(addr, `PHR_OFS_TX_LEN_HI)) begin
                s_d.len_hi = wdata;
            end
            if (hit_addr(addr, `PHR_OFS_TX_LEN_LO)) begin
                s_d.len_lo = wdata;
            end
        end

        // Rate setup time counts down after each configuration write.
        if (!(wr && hit_addr(addr, `PHR_OFS_TX_CFG)) && s_q.setup_cnt != '0) begin
            s_d.setup_cnt = s_q.setup_cnt - `PHR_SETUP_CNT_W'(1);
        end

        // Receive status follows the demodulator while enabled.
        if (!receive_enable_in) begin
            s_d.rx_rate = `PHR_RST_RATE;
            s_d.acq     = 1'b0;
            s_d.sfd     = 1'b0;
            s_d.sig_ok  = 1'b0;
            s_d.crc_ok  = 1'b0;
        end else begin
            s_d.acq = rx_evt.acquired;
            s_d.sfd = rx_evt.sfd_found;
            if (rx_evt.sig_valid) begin
                s_d.sig_ok = sig_hit;
                if (sig_hit) begin
                    s_d.rx_rate = sig_idx;
                end
            end
            if (rx_evt.crc_done) begin
                s_d.crc_ok = rx_evt.crc_ok;
            end
        end

        // Antenna and received fields are kept across receive disable.
        if (rx_evt.crc_done && rx_evt.crc_ok) begin
            s_d.ant_a = rx_evt.antenna_a;
        end
        if (rx_evt.svc_valid) begin
            s_d.rx_svc = rx_evt.svc_byte;
        end
        if (rx_evt.len_valid) begin
            s_d.rx_len = rx_evt.len;
        end

        // Read data stands for the one cycle after the strobe.
        s_d.rdata = `PHR_RST_BYTE;
        if (rd) begin
            unique case (addr)
                `PHR_OFS_TX_CFG:    s_d.rdata = s_q.cfg;
                `PHR_OFS_TX_SVC:    s_d.rdata = s_q.svc;
                `PHR_OFS_TX_LEN_HI: s_d.rdata = s_q.len_hi;
                `PHR_OFS_TX_LEN_LO: s_d.rdata = s_q.len_lo;
                `PHR_OFS_RX_STAT:   s_d.rdata = status_byte(s_q);
                `PHR_OFS_RX_SVC:    s_d.rdata = s_q.rx_svc;
                `PHR_OFS_RX_LEN_HI: s_d.rdata = s_q.rx_len[15:8];
                `PHR_OFS_RX_LEN_LO: s_d.rdata = s_q.rx_len[7:0];
                default:            s_d.rdata = `PHR_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata         = s_q.rdata;
    assign tx_rate_ready = (s_q.setup_cnt == '0);

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (srst);

    property p_nohdr_follows;
        wr && hit_addr(addr, `PHR_OFS_TX_CFG) |=> ##1
            tx_hdr.headerless == $past(wdata[`PHR_CFG_NOHDR_BIT], 2);
    endproperty
    a_nohdr_follows: assert property (p_nohdr_follows)
        else $error("Headerless flag does not follow configuration bit 2.");

    property p_sig_select;
        !srst |=> tx_hdr.signal == $past(codes[s_q.cfg[1:0]]);
    endproperty
    a_sig_select: assert property (p_sig_select)
        else $error("Transmit signal byte is not the code chosen by the rate.");

    property p_setup_time;
        wr && hit_addr(addr, `PHR_OFS_TX_CFG) |=> !tx_rate_ready [*8];
    endproperty
    a_setup_time: assert property (p_setup_time)
        else $error("Rate reported ready too soon after a write.");

    property p_service_out;
        wr && hit_addr(addr, `PHR_OFS_TX_SVC) |=> ##1 tx_hdr.service == $past(wdata, 2);
    endproperty
    a_service_out: assert property (p_service_out)
        else $error("Transmitted service byte differs from the written value.");

    property p_length_out;
        ##2 tx_hdr.length == {$past(s_q.len_hi), $past(s_q.len_lo)};
    endproperty
    a_length_out: assert property (p_length_out)
        else $error("Transmit length is not high byte over low byte.");

    property p_rx_clear;
        !receive_enable_in |=> s_q.rx_rate == 2'h0 && !s_q.acq && !s_q.sfd
                               && !s_q.sig_ok && !s_q.crc_ok;
    endproperty
    a_rx_clear: assert property (p_rx_clear)
        else $error("Receive status not cleared while receive is disabled.");

    property p_sig_nomatch;
        receive_enable_in && rx_evt.sig_valid && !sig_hit |=> !s_q.sig_ok;
    endproperty
    a_sig_nomatch: assert property (p_sig_nomatch)
        else $error("Signal valid set for a byte matching no code.");

    property p_crc_ant;
        rx_evt.crc_done && rx_evt.crc_ok |=> s_q.ant_a == $past(rx_evt.antenna_a)
                                             && s_q.crc_ok == $past(receive_enable_in);
    endproperty
    a_crc_ant: assert property (p_crc_ant)
        else $error("Good header check not recorded with its antenna.");

    property p_stat_bit0;
        rd && hit_addr(addr, `PHR_OFS_RX_STAT) |=> rdata[0] == 1'b0;
    endproperty
    a_stat_bit0: assert property (p_stat_bit0)
        else $error("Status bit 0 read back as one.");

    property p_ro_write;
        wr && !rx_evt.svc_valid && !rx_evt.len_valid |=>
            s_q.rx_svc == $past(s_q.rx_svc) && s_q.rx_len == $past(s_q.rx_len);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("Write changed a read-only receive field.");

    property p_rx_len_read;
        rx_evt.len_valid ##1 !rx_evt.len_valid
            ##1 (rd && hit_addr(addr, `PHR_OFS_RX_LEN_HI) && !rx_evt.len_valid)
            |=> rdata == $past(rx_evt.len[15:8], 3);
    endproperty
    a_rx_len_read: assert property (p_rx_len_read)
        else $error("Receive length high byte read wrong.");

    property p_rate_follows;
        wr && hit_addr(addr, `PHR_OFS_TX_CFG) |=>
            ##1 tx_hdr.rate == $past(wdata[1:0], 2);
    endproperty
    a_rate_follows: assert property (p_rate_follows)
        else $error("Transmit rate does not follow the written field.");

    property p_len_hi_out;
        wr && hit_addr(addr, `PHR_OFS_TX_LEN_HI) |=>
            ##1 tx_hdr.length[15:8] == $past(wdata, 2);
    endproperty
    a_len_hi_out: assert property (p_len_hi_out)
        else $error("Transmit length high byte differs from the written value.");

    property p_len_lo_out;
        wr && hit_addr(addr, `PHR_OFS_TX_LEN_LO) |=>
            ##1 tx_hdr.length[7:0] == $past(wdata, 2);
    endproperty
    a_len_lo_out: assert property (p_len_lo_out)
        else $error("Transmit length low byte differs from the written value.");

    property p_ready_after;
        s_q.setup_cnt == `PHR_SETUP_CNT_W'(1) && !(wr && hit_addr(addr, `PHR_OFS_TX_CFG))
            |=> tx_rate_ready;
    endproperty
    a_ready_after: assert property (p_ready_after)
        else $error("Rate not reported ready when the setup time ran out.");

    property p_acq_follow;
        receive_enable_in |=> s_q.acq == $past(rx_evt.acquired);
    endproperty
    a_acq_follow: assert property (p_acq_follow)
        else $error("Acquisition status does not follow the receiver.");

    property p_sfd_follow;
        receive_enable_in |=> s_q.sfd == $past(rx_evt.sfd_found);
    endproperty
    a_sfd_follow: assert property (p_sfd_follow)
        else $error("Delimiter status does not follow the receiver.");

    property p_sig_rate;
        receive_enable_in && rx_evt.sig_valid && sig_hit |=>
            s_q.sig_ok && codes[s_q.rx_rate] == $past(rx_evt.sig_byte);
    endproperty
    a_sig_rate: assert property (p_sig_rate)
        else $error("Detected rate does not name the matching code.");

    property p_crc_bad;
        receive_enable_in && rx_evt.crc_done && !rx_evt.crc_ok |=> !s_q.crc_ok;
    endproperty
    a_crc_bad: assert property (p_crc_bad)
        else $error("Bad header check reported as good.");

    property p_ant_hold;
        !(rx_evt.crc_done && rx_evt.crc_ok) |=> $stable(s_q.ant_a);
    endproperty
    a_ant_hold: assert property (p_ant_hold)
        else $error("Antenna bit changed without a good header check.");

    property p_svc_capture;
        rx_evt.svc_valid |=> s_q.rx_svc == $past(rx_evt.svc_byte);
    endproperty
    a_svc_capture: assert property (p_svc_capture)
        else $error("Received service byte not captured.");

    property p_len_capture;
        rx_evt.len_valid |=> s_q.rx_len == $past(rx_evt.len);
    endproperty
    a_len_capture: assert property (p_len_capture)
        else $error("Received length not captured.");

    property p_rdata_idle;
        !rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("Read data not zero outside a read.");

    property p_cfg_read;
        rd && hit_addr(addr, `PHR_OFS_TX_CFG) |=>
            rdata[2] == tx_hdr.headerless && rdata[1:0] == tx_hdr.rate;
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("Configuration read back disagrees with the header.");

    property p_svc_read;
        rd && hit_addr(addr, `PHR_OFS_TX_SVC) |=> rdata == tx_hdr.service;
    endproperty
    a_svc_read: assert property (p_svc_read)
        else $error("Service byte read back disagrees with the header.");

    c_headerless: cover property (wr && hit_addr(addr, `PHR_OFS_TX_CFG)
                                  && wdata[`PHR_CFG_NOHDR_BIT]);
    c_rate_11m: cover property (receive_enable_in && rx_evt.sig_valid && sig_hit
                                && sig_idx == 2'h3);
    c_crc_good: cover property (receive_enable_in && rx_evt.crc_done && rx_evt.crc_ok);
    c_sig_nomatch: cover property (receive_enable_in && rx_evt.sig_valid && !sig_hit);
    c_rx_off_evt: cover property (!receive_enable_in && rx_evt.sig_valid);

endmodule

`default_nettype wire

// ==== dv/phr_mac_model.sv ====
// Register bus master standing in for the controller that programs the bank.
`timescale 1ns/1ps
`default_nettype none

module phr_mac_model
    import phr_pkg::*;
(
    // Clock.
    input  wire logic       clk,
    // Register port.
    output logic [7:0]      addr,
    output logic [7:0]      wdata,
    output logic            wr,
    output logic            rd,
    // Transmit side.
    input  wire logic       tx_rate_ready,
    // Signal field codes.
    output phr_codes_type   codes
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        codes = {8'h6e, 8'h37, 8'h14, 8'h0a};
    end

    task automatic write(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic read(input logic [7:0] a);
        addr <= a;
        wdata <= ~wdata;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
    endtask

    // A released bus shows the inverse of its last value, not a held one.
    task automatic idle();
        addr <= ~addr;
        wdata <= ~wdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_ready(output int n);
        wr <= 1'b0;
        rd <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tx_rate_ready !== 1'b1 && n < 1000);
    endtask
endmodule
`default_nettype wire

// ==== dv/phr_regs_tb_top.sv ====
// Self-checking bench for the header field register bank.
`timescale 1ns/1ps
`default_nettype none
`include "phr_consts.svh"

module phr_regs_tb_top import phr_pkg::*;;
    logic           clk;
    logic           srst;
    logic           rx_en;
    logic           wr;
    logic           rd;
    logic           ready;
    logic           rd_seen;
    logic [7:0]     addr;
    logic [7:0]     wdata;
    logic [7:0]     rdata;
    phr_codes_type  codes;
    phr_rx_evt_type rx_evt;
    phr_rx_evt_type lvl;
    phr_tx_hdr_type tx_hdr;
    logic [7:0]     exp_q[$];
    string          name_q[$];
    int             err_count = 0;
    int             comparisons = 0;
    logic [7:0]     code_tab[4] = '{8'h0a, 8'h14, 8'h37, 8'h6e};
    logic [7:0]     ofs_tab[10] = '{8'h50, 8'h54, 8'h58, 8'h5c, 8'h60, 8'h64, 8'h68, 8'h6c,
                                    8'h70, 8'h51};

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    phr_regs DUT (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .codes(codes), .receive_enable_in(rx_en), .rx_evt(rx_evt),
        .tx_hdr(tx_hdr), .tx_rate_ready(ready));

    phr_mac_model mac (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .tx_rate_ready(ready), .codes(codes));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string name);
        exp_q.push_back(e);
        name_q.push_back(name);
        mac.read(a);
    endtask

    task automatic pulse(input phr_rx_evt_type e);
        rx_evt <= e;
        @(posedge clk);
        rx_evt <= lvl;
        @(posedge clk);
    endtask

    task automatic test_done();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe and read 00 otherwise.
    always @(posedge clk) begin
        if (srst) begin
            rd_seen <= 1'b0;
        end else begin
            if (rd_seen && exp_q.size() > 0) begin
                check(name_q.pop_front(), {8'h00, rdata}, {8'h00, exp_q.pop_front()});
            end else begin
                check("rdata_idle", {8'h00, rdata}, 16'h0000);
            end
            rd_seen <= rd;
        end
    end

    initial begin
        #100000;
        err_count++;
        test_done();
    end

    initial begin
        int                n;
        int                seed;
        logic [7:0]        cfg;
        logic [7:0]        svc;
        logic [7:0]        hi;
        logic [7:0]        lo;
        logic [15:0]       len;
        logic              ant;
        phr_rx_evt_type    e;
        seed = $urandom(39);
        srst <= 1'b1;
        rx_en <= 1'b0;
        lvl = '0;
        rx_evt <= '0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        foreach (ofs_tab[i]) rd_chk(ofs_tab[i], 8'h00, "reset_value");
        for (int r = 0; r < 5; r++) begin
            cfg = (r == 4) ? {5'($urandom), 3'b100} : {5'($urandom), 1'b0, 2'(r)};
            svc = 8'($urandom);
            hi = 8'($urandom);
            lo = 8'($urandom);
            mac.write(8'h54, svc);
            mac.write(8'h58, hi);
            mac.write(8'h5c, lo);
            mac.write(8'h50, cfg);
            mac.wait_ready(n);
            if (r == 0) check("setup_wait", 16'(n), 16'(`PHR_RATE_SETUP_CYC + 1));
            check("hdr_nohdr", {15'h0, tx_hdr.headerless}, {15'h0, cfg[2]});
            check("hdr_rate", {14'h0, tx_hdr.rate}, {14'h0, cfg[1:0]});
            check("hdr_signal", {8'h0, tx_hdr.signal}, {8'h0, code_tab[cfg[1:0]]});
            check("hdr_service", {8'h0, tx_hdr.service}, {8'h0, svc});
            check("hdr_length", tx_hdr.length, {hi, lo});
            rd_chk(8'h50, cfg, "cfg");
            rd_chk(8'h54, svc, "svc");
            rd_chk(8'h58, hi, "len_hi");
            rd_chk(8'h5c, lo, "len_lo");
            mac.idle();
        end
        rx_en <= 1'b1;
        lvl.acquired = 1'b1;
        lvl.sfd_found = 1'b1;
        for (int k = 0; k < 4; k++) begin
            ant = 1'($urandom);
            svc = 8'($urandom);
            len = 16'($urandom);
            e = lvl;
            e.sig_valid = 1'b1;
            e.sig_byte = code_tab[k];
            pulse(e);
            e = lvl;
            e.crc_done = 1'b1;
            e.crc_ok = 1'b1;
            e.antenna_a = ant;
            pulse(e);
            e = lvl;
            e.svc_valid = 1'b1;
            e.svc_byte = svc;
            e.len_valid = 1'b1;
            e.len = len;
            pulse(e);
            rd_chk(8'h68, len[15:8], "rx_len_hi");
            rd_chk(8'h60, {2'(k), 4'hf, ant, 1'b0}, "rx_status");
            rd_chk(8'h64, svc, "rx_svc");
            rd_chk(8'h6c, len[7:0], "rx_len_lo");
            mac.idle();
        end
        e = lvl;
        e.crc_done = 1'b1;
        e.antenna_a = ~ant;
        pulse(e);
        e = lvl;
        e.sig_valid = 1'b1;
        e.sig_byte = 8'h00;
        pulse(e);
        for (int i = 4; i < 8; i++) mac.write(ofs_tab[i], 8'hff);
        rd_chk(8'h60, {6'b111100, ant, 1'b0}, "rx_status_bad");
        rd_chk(8'h64, svc, "rx_svc_kept");
        rd_chk(8'h6c, len[7:0], "rx_len_kept");
        mac.idle();
        rx_en <= 1'b0;
        e = lvl;
        e.sig_valid = 1'b1;
        e.sig_byte = code_tab[2];
        pulse(e);
        rd_chk(8'h60, {6'b000000, ant, 1'b0}, "rx_status_off");
        rd_chk(8'h64, svc, "rx_svc_off");
        rd_chk(8'h68, len[15:8], "rx_len_off");
        mac.idle();
        repeat (2) @(posedge clk);
        test_done();
    end
endmodule
`default_nettype wire
